// ==== hw/iodr_consts.svh ====
`ifndef IODR_CONSTS_SVH
`define IODR_CONSTS_SVH

// register word addresses (byte address of the even byte)
`define IODR_ADDR_ACCEL_Y_LOW 7'h14
`define IODR_ADDR_ACCEL_Y_HIGH 7'h16
`define IODR_ADDR_ACCEL_Z_LOW 7'h18
`define IODR_ADDR_ACCEL_Z_HIGH 7'h1a
`define IODR_ADDR_TEMPERATURE 7'h1c
`define IODR_ADDR_ELAPSED 7'h1e
`define IODR_ADDR_COUNTER 7'h22
`define IODR_ADDR_DELTA_X_LOW 7'h24
`define IODR_ADDR_DELTA_X_HIGH 7'h26
`define IODR_ADDR_PARTNER_STEP 7'h02

// sync-mode field of the miscellaneous control register, bits 4 to 2
`define IODR_SYNC_SCALED 3'h2

`define IODR_COUNTER_RESET 16'h0000
`define IODR_ELAPSED_MAX 16'hffff
`define IODR_READ_NONE 16'h0000

// timing
`define IODR_CLK_PERIOD_NS 8
`define IODR_SAMPLE_RATE_SPS 2000
`define IODR_TS_LSB_US 49.02
`define IODR_FRAME_BITS 5'd16

// delta angle full-scale range in degrees, one of 360, 720, 2160
`define IODR_RANGE_DEG 360

`endif

// ==== hw/iodr_pkg.sv ====
package iodr_pkg;

    typedef struct packed {
        logic signed [31:0] gyro_x;
        logic signed [31:0] accel_y;
        logic signed [31:0] accel_z;
        logic signed [15:0] temperature;
    } iodr_sample_s;

    typedef struct packed {
        logic [31:0] accel_y;
        logic [31:0] accel_z;
        logic [15:0] temperature;
        logic [15:0] elapsed;
        logic [15:0] counter;
        logic [31:0] delta_angle_x;
    } iodr_outputs_s;

    typedef enum logic [1:0] {
        IODR_SPI_IDLE = 2'b01,
        IODR_SPI_SHIFT = 2'b10
    } iodr_spi_state_e;

endpackage

// ==== hw/iodr_output_data.sv ====
`timescale 1ns/1ps
`include "iodr_consts.svh"

module iodr_output_data
    import iodr_pkg::*;
#(
    parameter int SAMPLE_CYCLES = 1000000000 / (`IODR_SAMPLE_RATE_SPS * `IODR_CLK_PERIOD_NS),
    parameter int TS_CYCLES = $rtoi(`IODR_TS_LSB_US * 1000.0 / `IODR_CLK_PERIOD_NS),
    parameter int RANGE_DEG = `IODR_RANGE_DEG
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire iodr_sample_s sensor,
    input wire logic [15:0] decimation_setting,
    input wire logic [2:0] sync_mode,
    input wire logic reset_command,
    input wire logic sync_pin,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic sample_ready_pin
);

    function automatic logic [15:0] rd_word(input logic [6:0] a, input iodr_outputs_s r);
        case (a)
            `IODR_ADDR_ACCEL_Y_LOW: rd_word = r.accel_y[15:0];
            `IODR_ADDR_ACCEL_Y_HIGH: rd_word = r.accel_y[31:16];
            `IODR_ADDR_ACCEL_Z_LOW: rd_word = r.accel_z[15:0];
            `IODR_ADDR_ACCEL_Z_HIGH: rd_word = r.accel_z[31:16];
            `IODR_ADDR_TEMPERATURE: rd_word = r.temperature;
            `IODR_ADDR_ELAPSED: rd_word = r.elapsed;
            `IODR_ADDR_COUNTER: rd_word = r.counter;
            `IODR_ADDR_DELTA_X_LOW: rd_word = r.delta_angle_x[15:0];
            `IODR_ADDR_DELTA_X_HIGH: rd_word = r.delta_angle_x[31:16];
            default: rd_word = `IODR_READ_NONE;
        endcase
    endfunction

    function automatic logic is_low_word(input logic [6:0] a);
        is_low_word = (a == `IODR_ADDR_ACCEL_Y_LOW) || (a == `IODR_ADDR_ACCEL_Z_LOW)
            || (a == `IODR_ADDR_DELTA_X_LOW);
    endfunction

    function automatic logic [31:0] sat32(input logic signed [47:0] v);
        sat32 = (v > 48'sh00007fffffff) ? 32'h7fffffff
            : (v < -48'sh000080000000) ? 32'h80000000 : v[31:0];
    endfunction

    // internal sample clock
    logic [31:0] tick_div;
    logic sample_tick;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tick_div <= 32'h00000000;
        end
        else
        begin
            tick_div <= sample_tick ? 32'h00000000 : tick_div + 32'h00000001;
        end
    end

    assign sample_tick = (tick_div == 32'(SAMPLE_CYCLES - 1));

    // pin synchronisers: three stages, edges detected between stages two and three
    logic [3:0] sync1, sync2, sync3;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1 <= 4'h3;
            sync2 <= 4'h3;
            sync3 <= 4'h3;
        end
        else
        begin
            sync1 <= {sync_pin, spi_mosi, spi_sclk, spi_cs_n};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    logic cs_fall, cs_rise, sck_rise, sck_fall, sync_rise, mosi_s;

    assign cs_fall = !sync2[0] && sync3[0];
    assign cs_rise = sync2[0] && !sync3[0];
    assign sck_rise = sync2[1] && !sync3[1];
    assign sck_fall = !sync2[1] && sync3[1];
    assign mosi_s = sync2[2];
    assign sync_rise = sync2[3] && !sync3[3];

    // elapsed time since the last sync edge
    logic scaled_mode;
    logic [31:0] ts_div;
    logic [15:0] ts_cnt;

    assign scaled_mode = (sync_mode == `IODR_SYNC_SCALED);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ts_div <= 32'h00000000;
            ts_cnt <= 16'h0000;
        end
        else if (!scaled_mode || sync_rise)
        begin
            ts_div <= 32'h00000000;
            ts_cnt <= 16'h0000;
        end
        else if (ts_div >= 32'(TS_CYCLES - 1))
        begin
            ts_div <= 32'h00000000;
            // saturates rather than wrapping when sync stops arriving
            ts_cnt <= (ts_cnt == `IODR_ELAPSED_MAX) ? ts_cnt : ts_cnt + 16'h0001;
        end
        else
        begin
            ts_div <= ts_div + 32'h00000001;
        end
    end

    // trapezoidal delta angle integration
    logic [15:0] samp_cnt;
    logic signed [31:0] prev_gyro;
    logic signed [47:0] acc;
    logic signed [32:0] pair;
    logic signed [47:0] next_sum;
    logic signed [47:0] half_sum;
    logic update;

    assign pair = {sensor.gyro_x[31], sensor.gyro_x} + {prev_gyro[31], prev_gyro};
    assign next_sum = ((samp_cnt == 16'h0000) ? 48'sh0 : acc) + {{15{pair[32]}}, pair};
    // rate input is scaled so that one LSB times one sample period is one output LSB
    assign half_sum = next_sum >>> 1;
    assign update = sample_tick && (samp_cnt >= decimation_setting);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            samp_cnt <= 16'h0000;
            prev_gyro <= 32'sh0;
            acc <= 48'sh0;
        end
        else if (reset_command)
        begin
            samp_cnt <= 16'h0000;
            prev_gyro <= 32'sh0;
            acc <= 48'sh0;
        end
        else if (sample_tick)
        begin
            prev_gyro <= sensor.gyro_x;
            acc <= next_sum;
            samp_cnt <= update ? 16'h0000 : samp_cnt + 16'h0001;
        end
    end

    // output register set, loaded as one so every pair shares an update
    iodr_outputs_s outs;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            outs <= '0;
            outs.counter <= `IODR_COUNTER_RESET;
        end
        else if (reset_command)
        begin
            outs <= '0;
            outs.counter <= `IODR_COUNTER_RESET;
        end
        else if (update)
        begin
            outs.accel_y <= sensor.accel_y;
            outs.accel_z <= sensor.accel_z;
            outs.temperature <= sensor.temperature;
            outs.elapsed <= ts_cnt;
            outs.counter <= outs.counter + 16'h0001;
            outs.delta_angle_x <= sat32(half_sum);
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sample_ready_pin <= 1'b0;
        end
        else
        begin
            sample_ready_pin <= update;
        end
    end

    // serial register port, mode 3, 16-bit frames, answer in the next frame
    iodr_spi_state_e spi_state;
    logic [4:0] bit_cnt;
    logic [15:0] rx_sh;
    logic [15:0] tx_sh;
    logic [6:0] rd_addr;
    logic [15:0] hold_word;
    logic [6:0] hold_addr;
    logic hold_valid;
    logic hold_hit;

    assign hold_hit = hold_valid && (rd_addr == hold_addr);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            spi_state <= IODR_SPI_IDLE;
            bit_cnt <= 5'd0;
            rx_sh <= 16'h0000;
            tx_sh <= 16'h0000;
            spi_miso <= 1'b0;
            rd_addr <= 7'h00;
        end
        else
        begin
            case (spi_state)
                IODR_SPI_IDLE:
                begin
                    if (cs_fall)
                    begin
                        spi_state <= IODR_SPI_SHIFT;
                        bit_cnt <= 5'd0;
                        tx_sh <= hold_hit ? hold_word : rd_word(rd_addr, outs);
                    end
                end
                IODR_SPI_SHIFT:
                begin
                    if (cs_rise)
                    begin
                        spi_state <= IODR_SPI_IDLE;
                        // write frames carry bit 15 set and are dropped here
                        if (bit_cnt == `IODR_FRAME_BITS && !rx_sh[15])
                        begin
                            rd_addr <= rx_sh[14:8];
                        end
                    end
                    else
                    begin
                        if (sck_rise)
                        begin
                            rx_sh <= {rx_sh[14:0], mosi_s};
                            bit_cnt <= bit_cnt + 5'd1;
                        end
                        if (sck_fall)
                        begin
                            spi_miso <= tx_sh[15];
                            tx_sh <= {tx_sh[14:0], 1'b0};
                        end
                    end
                end
                default:
                begin
                    spi_state <= IODR_SPI_IDLE;
                end
            endcase
        end
    end

    // reading a low word freezes its high partner for the following read
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold_word <= 16'h0000;
            hold_addr <= 7'h00;
            hold_valid <= 1'b0;
        end
        else if (spi_state == IODR_SPI_IDLE && cs_fall)
        begin
            hold_word <= rd_word(rd_addr + `IODR_ADDR_PARTNER_STEP, outs);
            hold_addr <= rd_addr + `IODR_ADDR_PARTNER_STEP;
            hold_valid <= !hold_hit && is_low_word(rd_addr);
        end
    end

    assign spi_miso_oe = (spi_state == IODR_SPI_SHIFT);

    logic [15:0] ticks_seen; // kept apart from samp_cnt so the decimation check is independent

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ticks_seen <= 16'h0000;
        end
        else
        begin
            ticks_seen <= (reset_command || update) ? 16'h0000 : ticks_seen + 16'(sample_tick);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_update;
        update && !reset_command;
    endsequence

    sequence s_scaled_edge;
        sync_rise && scaled_mode;
    endsequence

    counter_step_a: assert property (s_update |=> outs.counter == $past(outs.counter) + 16'h0001)
        else $error("update counter did not step by one");
    counter_wrap_a: assert property (s_update ##0 outs.counter == 16'hffff |=> outs.counter == 16'h0000)
        else $error("update counter did not wrap");
    counter_clear_a: assert property (reset_command |=> outs.counter == `IODR_COUNTER_RESET)
        else $error("update counter not cleared by reset command");
    decim_span_a: assert property (sample_tick && !reset_command
        |-> update == (ticks_seen >= decimation_setting))
        else $error("update not on the tick that completes the decimation window");
    tick_spacing_a: assert property (sample_tick |=> !sample_tick)
        else $error("sample ticks back to back");
    accel_load_a: assert property (s_update |=> outs.accel_y == $past(sensor.accel_y)
        && outs.accel_z == $past(sensor.accel_z))
        else $error("accel pair not loaded from the update sample");
    temp_load_a: assert property (s_update |=> outs.temperature == $past(sensor.temperature))
        else $error("temperature not loaded on update");
    elapsed_zero_a: assert property (s_scaled_edge |=> ts_cnt == 16'h0000)
        else $error("elapsed time not restarted at sync edge");
    elapsed_mode_a: assert property (!scaled_mode |=> ts_cnt == 16'h0000)
        else $error("elapsed time counts outside scaled mode");
    elapsed_latch_a: assert property (s_update |=> outs.elapsed == $past(ts_cnt))
        else $error("elapsed word not taken from last sample");
    outputs_hold_a: assert property (!update && !reset_command |=> $stable(outs))
        else $error("output registers changed without an update");
    pair_hold_a: assert property (spi_state == IODR_SPI_IDLE && cs_fall && hold_hit
        |=> tx_sh == $past(hold_word))
        else $error("high word not served from the held pair");

endmodule

// ==== tb/iodr_host_model.sv ====
`timescale 1ns/1ps
module iodr_host_model
(
    input wire logic clk,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    localparam int HALF = 4;

    initial
    begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b1;
        spi_mosi = 1'b0;
    end

    // data line is let go between frames; toggling keeps a stale level from passing as data
    always @(posedge clk)
    begin
        if (spi_cs_n)
            spi_mosi <= ~spi_mosi;
    end

    // one mode-3 frame; the bits shifted in answer the previous command
    // miso is taken just before the next fall, well after the synchroniser delay
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        rsp = 16'h0000;
        @(posedge clk);
        spi_cs_n <= 1'b0;
        repeat (HALF) @(posedge clk);
        for (int i = 15; i >= 0; i--)
        begin
            if (i < 15)
                rsp[i + 1] = spi_miso_oe ? spi_miso : 1'bx;
            spi_sclk <= 1'b0;
            spi_mosi <= cmd[i];
            repeat (HALF) @(posedge clk);
            spi_sclk <= 1'b1;
            repeat (HALF) @(posedge clk);
        end
        rsp[0] = spi_miso_oe ? spi_miso : 1'bx;
        spi_cs_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
endmodule

// ==== tb/iodr_output_data_tb.sv ====
`timescale 1ns/1ps
module iodr_output_data_tb
    import iodr_pkg::*;
;
    localparam int SC = 40;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    iodr_sample_s sensor;
    logic [15:0] dec = 16'd99;
    logic [2:0] sync_mode = 3'h0;
    logic reset_command = 1'b0;
    logic sync_pin = 1'b0;
    wire spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, sample_ready_pin;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    int t0;
    logic [15:0] r;
    logic [6:0] addr_tbl [9] = '{7'h14, 7'h16, 7'h18, 7'h1a, 7'h1c, 7'h1e, 7'h22, 7'h24, 7'h26};
    logic [15:0] exp_tbl [9];

    initial sensor = '{32'sh0001_0002, 32'sh7d00_0001, 32'sh8300_ffff, 16'shfe70};

    iodr_output_data #(.SAMPLE_CYCLES(SC), .TS_CYCLES(4)) iodr_output_data_i (
        .clk(clk), .arst_n(arst_n), .sensor(sensor), .decimation_setting(dec),
        .sync_mode(sync_mode), .reset_command(reset_command), .sync_pin(sync_pin),
        .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .sample_ready_pin(sample_ready_pin)
    );

    iodr_host_model iodr_host_model_i (
        .clk(clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe)
    );

    always #4 clk = ~clk;

    // cycle count for the rate check and the run ceiling
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            miscompares++;
            $display("ERROR at %0t: timeout", $time);
            summarize();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic rd(input logic [6:0] addr, output logic [15:0] rsp);
        iodr_host_model_i.xfer({1'b0, addr, 8'h00}, rsp);
    endtask

    task automatic wait_update();
        int n;
        n = 0;
        @(posedge clk);
        while (sample_ready_pin !== 1'b1 && n < 9000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 9000)
        begin
            miscompares++;
            $display("ERROR at %0t: no data update", $time);
        end
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(7'h22, r);
        rd(7'h14, r);
        check(r, 16'h0000, "counter after reset");
        $display("test reset done");

        // second update so the trapezoid has a steady previous sample
        wait_update();
        wait_update();
        exp_tbl = '{16'h0001, 16'h7d00, 16'hffff, 16'h8300, 16'hfe70, 16'h0000,
                    16'h0002, 16'h00c8, 16'h0064};
        rd(addr_tbl[0], r);
        for (int i = 1; i < 9; i++)
        begin
            rd(addr_tbl[i], r);
            check(r, exp_tbl[i - 1], "output word");
        end
        rd(7'h22, r);
        check(r, exp_tbl[8], "delta high");
        iodr_host_model_i.xfer(16'ha2a5, r);
        check(r, exp_tbl[6], "counter before write");
        rd(7'h1c, r);
        check(r, exp_tbl[6], "counter after write");
        $display("test data set done");

        // low word read before an update, high word after it
        rd(7'h14, r);
        rd(7'h16, r);
        sensor.accel_y <= 32'sh0002_1234;
        wait_update();
        rd(7'h22, r);
        check(r, 16'h7d00, "paired high");
        rd(7'h16, r);
        rd(7'h22, r);
        check(r, 16'h0002, "unpaired high");
        $display("test pairing done");

        sync_mode <= 3'h2;
        wait_update();
        sync_pin <= 1'b1;
        repeat (4) @(posedge clk);
        sync_pin <= 1'b0;
        wait_update();
        rd(7'h1e, r);
        rd(7'h22, r);
        check({15'h0000, (r >= 16'd996 && r <= 16'd1000)}, 16'h0001, "elapsed");
        $display("test elapsed done");

        wait_update();
        reset_command <= 1'b1;
        @(posedge clk);
        reset_command <= 1'b0;
        rd(7'h22, r);
        rd(7'h14, r);
        check(r, 16'h0000, "counter after command");
        wait_update();
        rd(7'h22, r);
        rd(7'h14, r);
        check(r, 16'h0001, "counter after update");
        $display("test command done");

        sensor.gyro_x <= -32'sd2;
        dec <= 16'd3;
        repeat (3) wait_update();
        rd(7'h24, r);
        rd(7'h26, r);
        check(r, 16'hfff8, "delta low d4");
        rd(7'h22, r);
        check(r, 16'hffff, "delta high d4");
        $display("test decimation done");

        // rate measured on the pin with no decimation
        dec <= 16'd0;
        repeat (2) wait_update();
        t0 = cycles;
        wait_update();
        check(16'(cycles - t0), 16'(SC), "pin period");
        $display("test rate done");
        summarize();
    end
endmodule
